//--- hdl/sarseq_pkg.sv
// Package for the converter sequencer: register map, field positions, reset values, encodings.
// Assumes a single 20 MHz system clock and a plain strobe-based register port.
package sarseq_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] SARSEQ_OFF_CTRL   = 4'h0;
  localparam logic [3:0] SARSEQ_OFF_MUX    = 4'h1;
  localparam logic [3:0] SARSEQ_OFF_DATA   = 4'h2;
  localparam logic [3:0] SARSEQ_OFF_WLO    = 4'h3;
  localparam logic [3:0] SARSEQ_OFF_WHI    = 4'h4;
  localparam logic [3:0] SARSEQ_OFF_STATUS = 4'h5;
  localparam logic [3:0] SARSEQ_OFF_MASK   = 4'h6;
  localparam logic [3:0] SARSEQ_OFF_CMD    = 4'h7;

  // Control register fields.
  localparam int SARSEQ_CTRL_EN      = 0;
  localparam int SARSEQ_CTRL_SRC_LO  = 1;
  localparam int SARSEQ_CTRL_ACC_LO  = 3;
  localparam int SARSEQ_CTRL_BURST   = 5;
  localparam int SARSEQ_CTRL_WOUT    = 6;
  localparam int SARSEQ_CTRL_BG      = 7;
  localparam logic [7:0] SARSEQ_CTRL_RST = 8'h00;

  // Status and mask bit positions.
  localparam int SARSEQ_ST_DONE = 0;
  localparam int SARSEQ_ST_WIN  = 1;
  localparam logic [1:0] SARSEQ_MASK_RST = 2'h0;

  // Command register: writing this bit issues a software start.
  localparam int SARSEQ_CMD_START = 0;

  // Input selector codes above the sixteen port pins.
  localparam logic [4:0] SARSEQ_MUX_TEMP = 5'h10;
  localparam logic [4:0] SARSEQ_MUX_VDD  = 5'h11;
  localparam logic [4:0] SARSEQ_MUX_RST  = 5'h00;

  // Window bounds reset to the full range.
  localparam logic [15:0] SARSEQ_WLO_RST = 16'h0000;
  localparam logic [15:0] SARSEQ_WHI_RST = 16'hffff;

  // Start source encodings.
  typedef enum logic [1:0] {
    SARSEQ_SRC_SW  = 2'b00,
    SARSEQ_SRC_TM1 = 2'b01,
    SARSEQ_SRC_TM2 = 2'b10,
    SARSEQ_SRC_EXT = 2'b11
  } sarseq_src_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    SARSEQ_ST_IDLE = 2'b00,
    SARSEQ_ST_WAKE = 2'b01,
    SARSEQ_ST_CONV = 2'b10,
    SARSEQ_ST_DONE_S = 2'b11
  } sarseq_state_t;

  // Timing: wake-up time from shutdown in burst mode.
  localparam int SARSEQ_CLK_HZ     = 20_000_000;
  localparam int SARSEQ_WAKE_NS    = 1000;
  localparam int SARSEQ_WAKE_CYC   = (SARSEQ_WAKE_NS * (SARSEQ_CLK_HZ / 1_000_000) + 999) / 1000;

endpackage

//--- hdl/sarseq_top.sv
// Sequencer around a 12-bit successive-approximation converter core.
// Assumes the analog core takes a sample request pulse and returns a done pulse with data,
// all on mclk_i; timer overflows and the external start are synchronous single-cycle pulses.
// Notes on behaviour
// - Start comes from software, timer one, timer two or external input, as selected.
// - Completion is reported only after 1, 4, 8 or 16 samples are summed.
// - The summed result, 12 to 16 bits, is latched into the data register.
// - Each completion sets a done flag; if enabled it raises the interrupt.
// - Burst mode wakes the core on a start and shuts it down afterwards.
// - Each result is checked against low and high bounds, inside or outside.
// - In background mode only the window condition may interrupt.
// - Selector routes a port pin, temperature sensor or supply to the positive input.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module sarseq_top
  import sarseq_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  input  wire logic        tmr1_ovf_i,
  input  wire logic        tmr2_ovf_i,
  input  wire logic        ext_start_i,
  output logic             conv_req_o,
  input  wire logic        conv_done_i,
  input  wire logic [11:0] conv_data_i,
  output logic             power_on_o,
  output logic [4:0]       mux_sel_o,
  output logic             busy_o,
  output logic             irq_o
);

  // The accumulator width is sized for a 12-bit sample summed sixteen times.
  initial begin
    if (SAMPLE_W != 12) begin
      $error("sarseq_top serves 12-bit samples only");
    end
  end

  // Decode the accumulation count field into a sample total.
  function automatic logic [4:0] acc_count(input logic [1:0] code);
    case (code)
      2'b00:   acc_count = 5'h01;
      2'b01:   acc_count = 5'h04;
      2'b10:   acc_count = 5'h08;
      default: acc_count = 5'h10;
    endcase
  endfunction

  logic [7:0]    ctrl_reg, ctrl_next;
  logic [4:0]    mux_reg, mux_next;
  logic [15:0]   wlo_reg, wlo_next;
  logic [15:0]   whi_reg, whi_next;
  logic [1:0]    mask_reg, mask_next;
  logic [1:0]    stat_reg, stat_next;
  logic [15:0]   data_reg, data_next;
  logic [15:0]   rdata_reg, rdata_next;
  logic [15:0]   acc_reg, acc_next;
  logic [4:0]    cnt_reg, cnt_next;
  logic [4:0]    tgt_reg, tgt_next;
  logic [7:0]    wake_reg, wake_next;
  logic          req_reg, req_next;
  logic          pwr_reg, pwr_next;
  sarseq_state_t st_reg, st_next;

  logic        enabled;
  logic        burst;
  logic        start_hit;
  logic        sw_start;
  logic        done_evt;
  logic        win_evt;
  logic        in_win;
  logic [15:0] final_sum;
  sarseq_src_t src;

  assign enabled = ctrl_reg[SARSEQ_CTRL_EN];
  assign burst   = ctrl_reg[SARSEQ_CTRL_BURST];
  assign src     = sarseq_src_t'(ctrl_reg[SARSEQ_CTRL_SRC_LO +: 2]);
  assign sw_start = wr_i && (addr_i == SARSEQ_OFF_CMD) && wdata_i[SARSEQ_CMD_START];

  always_comb begin
    case (src)
      SARSEQ_SRC_SW:  start_hit = sw_start;
      SARSEQ_SRC_TM1: start_hit = tmr1_ovf_i;
      SARSEQ_SRC_TM2: start_hit = tmr2_ovf_i;
      SARSEQ_SRC_EXT: start_hit = ext_start_i;
      default:        start_hit = 1'b0;
    endcase
  end

  // Sum that the incoming sample completes; used both for the data latch and the compare.
  assign final_sum = acc_reg + {4'h0, conv_data_i};

  assign in_win = (final_sum >= wlo_reg) && (final_sum <= whi_reg);

  // Sequencer: wake, sample, accumulate, finish.
  always_comb begin
    st_next   = st_reg;
    acc_next  = acc_reg;
    cnt_next  = cnt_reg;
    tgt_next  = tgt_reg;
    wake_next = wake_reg;
    req_next  = 1'b0;
    data_next = data_reg;
    done_evt  = 1'b0;
    win_evt   = 1'b0;
    // Outside burst mode the core stays powered whenever enabled.
    pwr_next  = enabled && (!burst || (st_reg != SARSEQ_ST_IDLE));
    case (st_reg)
      SARSEQ_ST_IDLE: begin
        if (enabled && start_hit) begin
          acc_next = 16'h0000;
          cnt_next = 5'h00;
          tgt_next = acc_count(ctrl_reg[SARSEQ_CTRL_ACC_LO +: 2]);
          if (burst) begin
            pwr_next  = 1'b1;
            wake_next = 8'(SARSEQ_WAKE_CYC);
            st_next   = SARSEQ_ST_WAKE;
          end else begin
            req_next = 1'b1;
            st_next  = SARSEQ_ST_CONV;
          end
        end
      end
      SARSEQ_ST_WAKE: begin
        if (wake_reg <= 8'h01) begin
          req_next = 1'b1;
          st_next  = SARSEQ_ST_CONV;
        end else begin
          wake_next = wake_reg - 8'h01;
        end
      end
      SARSEQ_ST_CONV: begin
        if (!enabled) begin
          st_next = SARSEQ_ST_IDLE;
        end else if (conv_done_i) begin
          acc_next = final_sum;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg + 5'h01 >= tgt_reg) begin
            data_next = final_sum;
            done_evt  = 1'b1;
            win_evt   = in_win ^ ctrl_reg[SARSEQ_CTRL_WOUT];
            st_next   = SARSEQ_ST_DONE_S;
          end else begin
            req_next = 1'b1;
          end
        end
      end
      SARSEQ_ST_DONE_S: begin
        pwr_next = enabled && !burst;
        st_next  = SARSEQ_ST_IDLE;
      end
      default: st_next = SARSEQ_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_reg   <= SARSEQ_ST_IDLE;
      acc_reg  <= 16'h0000;
      cnt_reg  <= 5'h00;
      tgt_reg  <= 5'h01;
      wake_reg <= 8'h00;
      req_reg  <= 1'b0;
      pwr_reg  <= 1'b0;
      data_reg <= 16'h0000;
    end else begin
      st_reg   <= st_next;
      acc_reg  <= acc_next;
      cnt_reg  <= cnt_next;
      tgt_reg  <= tgt_next;
      wake_reg <= wake_next;
      req_reg  <= req_next;
      pwr_reg  <= pwr_next;
      data_reg <= data_next;
    end
  end

  // Register writes, status flags and read data.  A set in the same cycle as the
  // clearing read wins, so a completion is never lost.
  always_comb begin
    ctrl_next  = ctrl_reg;
    mux_next   = mux_reg;
    wlo_next   = wlo_reg;
    whi_next   = whi_reg;
    mask_next  = mask_reg;
    stat_next  = stat_reg;
    rdata_next = 16'h0000;
    if (wr_i) begin
      case (addr_i)
        SARSEQ_OFF_CTRL: ctrl_next = wdata_i[7:0];
        SARSEQ_OFF_MUX:  mux_next  = wdata_i[4:0];
        SARSEQ_OFF_WLO:  wlo_next  = wdata_i;
        SARSEQ_OFF_WHI:  whi_next  = wdata_i;
        SARSEQ_OFF_MASK: mask_next = wdata_i[1:0];
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        SARSEQ_OFF_CTRL:   rdata_next = {8'h00, ctrl_reg};
        SARSEQ_OFF_MUX:    rdata_next = {11'h000, mux_reg};
        SARSEQ_OFF_DATA:   rdata_next = data_reg;
        SARSEQ_OFF_WLO:    rdata_next = wlo_reg;
        SARSEQ_OFF_WHI:    rdata_next = whi_reg;
        SARSEQ_OFF_STATUS: begin
          rdata_next = {13'h0000, st_reg != SARSEQ_ST_IDLE, stat_reg};
          stat_next  = 2'h0;
        end
        SARSEQ_OFF_MASK:   rdata_next = {14'h0000, mask_reg};
        default:           rdata_next = 16'h0000;
      endcase
    end
    if (done_evt) begin
      stat_next[SARSEQ_ST_DONE] = 1'b1;
    end
    if (win_evt) begin
      stat_next[SARSEQ_ST_WIN] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_reg  <= SARSEQ_CTRL_RST;
      mux_reg   <= SARSEQ_MUX_RST;
      wlo_reg   <= SARSEQ_WLO_RST;
      whi_reg   <= SARSEQ_WHI_RST;
      mask_reg  <= SARSEQ_MASK_RST;
      stat_reg  <= 2'h0;
      rdata_reg <= 16'h0000;
    end else begin
      ctrl_reg  <= ctrl_next;
      mux_reg   <= mux_next;
      wlo_reg   <= wlo_next;
      whi_reg   <= whi_next;
      mask_reg  <= mask_next;
      stat_reg  <= stat_next;
      rdata_reg <= rdata_next;
    end
  end

  assign irq_o = (stat_reg[SARSEQ_ST_DONE] && mask_reg[SARSEQ_ST_DONE]
                  && !ctrl_reg[SARSEQ_CTRL_BG])
              || (stat_reg[SARSEQ_ST_WIN] && mask_reg[SARSEQ_ST_WIN]);

  assign rdata_o    = rdata_reg;
  assign conv_req_o = req_reg;
  assign power_on_o = pwr_reg;
  assign mux_sel_o  = mux_reg;
  assign busy_o     = (st_reg != SARSEQ_ST_IDLE);

endmodule

//--- testbench/sarseq_top_sva.sv
// Checker for the converter sequencer, bound to the top module.
// Assumes settings change only by register writes on this port.
`timescale 1ns/1ps
module sarseq_top_sva
  import sarseq_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        tmr1_ovf_i,
  input wire logic        tmr2_ovf_i,
  input wire logic        ext_start_i,
  input wire logic        conv_req_o,
  input wire logic        conv_done_i,
  input wire logic [11:0] conv_data_i,
  input wire logic        power_on_o,
  input wire logic [4:0]  mux_sel_o,
  input wire logic        busy_o,
  input wire logic        irq_o
);
  logic [7:0] c_sh;
  logic [1:0] m_sh;
  // Shadows of control and mask, so the rules can see the settings.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      c_sh <= SARSEQ_CTRL_RST;
      m_sh <= SARSEQ_MASK_RST;
    end else if (wr_i && addr_i == SARSEQ_OFF_CTRL) begin
      c_sh <= wdata_i[7:0];
    end else if (wr_i && addr_i == SARSEQ_OFF_MASK) begin
      m_sh <= wdata_i[1:0];
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_bst;
    wr_i && addr_i == SARSEQ_OFF_CMD && wdata_i[0] && !busy_o && c_sh[5:0] == 6'h21;
  endsequence
  sequence s_wake;
    (power_on_o && !conv_req_o) [*8] ##[9:14] conv_req_o;
  endsequence
  property p_rdat; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
  a_rdat: assert property (p_rdat) else $error("read data outside its cycle");
  property p_reqb; conv_req_o |-> busy_o; endproperty
  a_reqb: assert property (p_reqb) else $error("sample request while idle");
  property p_reqp; conv_req_o |-> power_on_o; endproperty
  a_reqp: assert property (p_reqp) else $error("sample request while off");
  property p_ext;
    ext_start_i && !busy_o && c_sh[5:0] == 6'h07 |=> conv_req_o && busy_o;
  endproperty
  a_ext: assert property (p_ext) else $error("external start not taken");
  property p_imsk; irq_o |-> m_sh != 2'h0; endproperty
  a_imsk: assert property (p_imsk) else $error("interrupt while masked");
  property p_idone;
    $fell(busy_o) && c_sh[0] && !c_sh[7] && m_sh[0] && !$past(rd_i) |-> irq_o;
  endproperty
  a_idone: assert property (p_idone) else $error("no completion interrupt");
  property p_wake; s_bst |=> s_wake; endproperty
  a_wake: assert property (p_wake) else $error("burst wake order wrong");
  property p_mux;
    wr_i && addr_i == SARSEQ_OFF_MUX |=> mux_sel_o == $past(wdata_i[4:0]);
  endproperty
  a_mux: assert property (p_mux) else $error("input select not applied");
endmodule
bind sarseq_top sarseq_top_sva i_sarseq_top_sva (
  .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .tmr1_ovf_i(tmr1_ovf_i), .tmr2_ovf_i(tmr2_ovf_i),
  .ext_start_i(ext_start_i), .conv_req_o(conv_req_o), .conv_done_i(conv_done_i),
  .conv_data_i(conv_data_i), .power_on_o(power_on_o), .mux_sel_o(mux_sel_o),
  .busy_o(busy_o), .irq_o(irq_o));

//--- testbench/sarseq_core_model.sv
// Model of the analog core: one sample three cycles after a request.
// Assumes requests are single-cycle pulses on the system clock.
`timescale 1ns/1ps
module sarseq_core_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        conv_req_i,
  input  wire logic        power_on_i,
  input  wire logic [4:0]  mux_sel_i,
  output logic             conv_done_o,
  output logic [11:0]      conv_data_o
);
  logic        pend;
  logic [1:0]  cnt;
  logic [11:0] last;
  // selected input, powered
  // Data lines show junk between samples; a request made while unpowered is never answered.
  always_ff @(posedge mclk_i) begin
    conv_done_o <= 1'b0;
    conv_data_o <= ~last;
    if (rst_i) begin
      pend <= 1'b0;
      last <= 12'h000;
    end else if (conv_req_i && power_on_i) begin
      pend <= 1'b1;
      cnt <= 2'h2;
    end else if (pend && cnt == 2'h0) begin
      pend <= 1'b0;
      conv_done_o <= 1'b1;
      conv_data_o <= 12'h800 | {7'h00, mux_sel_i};
      last <= 12'h800 | {7'h00, mux_sel_i};
    end else if (pend) begin
      cnt <= cnt - 2'h1;
    end
  end
endmodule

//--- testbench/sarseq_top_bench.sv
// Bench for the converter sequencer with the core model beside it.
// Assumes the package map; start inputs are single-cycle pulses.
`timescale 1ns/1ps
module sarseq_top_bench;
  import sarseq_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [2:0]  trig = 3'h0;
  logic [15:0] rdata_o, rv;
  logic        req, done, pwr, busy_o, irq_o;
  logic [11:0] cdata;
  logic [4:0]  mux_sel_o;
  int          err_count = 0;
  int          checks = 0;
  int          cyc = 0;
  // One start per sample slot at the top rate: 20 MHz over 200 ksps is 100 cycles.
  localparam int START_GAP = 100;
  always #25 mclk_i = ~mclk_i;
  sarseq_top i_sarseq_top (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tmr1_ovf_i(trig[0]),
    .tmr2_ovf_i(trig[1]), .ext_start_i(trig[2]), .conv_req_o(req), .conv_done_i(done),
    .conv_data_i(cdata), .power_on_o(pwr), .mux_sel_o(mux_sel_o), .busy_o(busy_o),
    .irq_o(irq_o));
  sarseq_core_model i_sarseq_core_model (.mclk_i(mclk_i), .rst_i(rst_i), .conv_req_i(req),
    .power_on_i(pwr), .mux_sel_i(mux_sel_o), .conv_done_o(done), .conv_data_o(cdata));
  task automatic stop_test();
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  // Waits for the group to end, with a bound so a hang is reported.
  task automatic idle();
    #1;
    for (int i = 0; i < 400 && busy_o !== 1'b0; i++) @(posedge mclk_i) #1;
    chk("busy", 16'h0, {15'h0, busy_o});
  endtask
  task automatic pulse(input int i);
    @(posedge mclk_i);
    trig[i] <= 1'b1;
    @(posedge mclk_i);
    trig[i] <= 1'b0;
    #1;
  endtask
  task automatic run(input logic [7:0] c, input logic [4:0] m);
    wr(SARSEQ_OFF_MUX, {11'h0, m});
    wr(SARSEQ_OFF_CTRL, {8'h0, c});
    repeat (START_GAP) @(posedge mclk_i);
    wr(SARSEQ_OFF_CMD, 16'h0001);
    idle();
  endtask
  // Reset values, and an unmapped place that ignores writes.
  task automatic t_reset();
    wr(4'hf, 16'hffff);
    rd(4'hf);
    chk("unmapped", 16'h0, rv);
    rd(SARSEQ_OFF_WHI);
    chk("win high", SARSEQ_WHI_RST, rv);
    rd(SARSEQ_OFF_CTRL);
    chk("ctrl", {8'h0, SARSEQ_CTRL_RST}, rv);
  endtask
  // Every sample count, with port pins, sensor and supply selected.
  task automatic t_count();
    logic [4:0] mx [4] = '{5'h03, 5'h0f, SARSEQ_MUX_TEMP, SARSEQ_MUX_VDD};
    for (int k = 0; k < 4; k++) begin
      run({3'h0, k[1:0], 3'h1}, mx[k]);
      chk("mux", {11'h0, mx[k]}, {11'h0, mux_sel_o});
      chk("irq masked", 16'h0, {15'h0, irq_o});
      rd(SARSEQ_OFF_DATA);
      chk("data", (16'h1 << (k == 0 ? 0 : k + 1)) * (16'h0800 | {11'h0, mx[k]}), rv);
      rd(SARSEQ_OFF_STATUS);
      chk("status", 16'h0003, rv);
      rd(SARSEQ_OFF_STATUS);
      chk("status clear", 16'h0, rv);
    end
  endtask
  // Timer one, timer two, external: other sources and starts while busy do nothing.
  task automatic t_source();
    wr(SARSEQ_OFF_MUX, 16'h0);
    for (int s = 1; s < 4; s++) begin
      wr(SARSEQ_OFF_CTRL, {13'h0, s[1:0], 1'b1});
      repeat (START_GAP) @(posedge mclk_i);
      pulse(s % 3);
      chk("busy other", 16'h0, {15'h0, busy_o});
      pulse(s - 1);
      chk("busy start", 16'h1, {15'h0, busy_o});
      pulse(s - 1);
      idle();
      repeat (3) @(posedge mclk_i) #1;
      chk("busy ignored", 16'h0, {15'h0, busy_o});
      rd(SARSEQ_OFF_DATA);
      chk("data one", 16'h0800, rv);
    end
  endtask
  // Window inside, outside and background interrupts.
  task automatic t_irq();
    rd(SARSEQ_OFF_STATUS);
    wr(SARSEQ_OFF_MASK, 16'h0001);
    wr(SARSEQ_OFF_WLO, 16'h0900);
    run(8'h01, 5'h03);
    chk("irq done", 16'h1, {15'h0, irq_o});
    rd(SARSEQ_OFF_STATUS);
    chk("status inside", 16'h0001, rv);
    wr(SARSEQ_OFF_MASK, 16'h0003);
    run(8'h41, 5'h03);
    rd(SARSEQ_OFF_STATUS);
    chk("status outside", 16'h0003, rv);
    run(8'h81, 5'h03);
    chk("irq bg", 16'h0, {15'h0, irq_o});
    wr(SARSEQ_OFF_WLO, 16'h0000);
    run(8'h81, 5'h03);
    chk("irq bg win", 16'h1, {15'h0, irq_o});
  endtask
  // Disabled start, then a burst group that sleeps again.
  task automatic t_burst();
    wr(SARSEQ_OFF_CTRL, 16'h0);
    wr(SARSEQ_OFF_CMD, 16'h0001);
    repeat (2) @(posedge mclk_i) #1;
    chk("busy off", 16'h0, {15'h0, busy_o});
    chk("power off", 16'h0, {15'h0, pwr});
    run(8'h21, 5'h05);
    repeat (3) @(posedge mclk_i) #1;
    chk("power", 16'h0, {15'h0, pwr});
    rd(SARSEQ_OFF_DATA);
    chk("data burst", 16'h0805, rv);
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_count();
    t_source();
    t_irq();
    t_burst();
    stop_test();
  end
  // Hang guard, well above the fewer than two thousand cycles the run needs.
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
endmodule
